// ---- ldcr_deglitch.sv ----
`timescale 1ns/1ps

module ldcr_deglitch #(
    parameter int unsigned W = 13
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Filter
    input  wire logic         raw,
    input  wire logic [W-1:0] limit,
    output logic              filtered
);
    logic [W-1:0] cnt_q;

    // The output rises only after raw has stood for limit cycles.
    always_ff @(posedge clk) begin
        if (rst || !raw) begin
            cnt_q    <= '0;
            filtered <= 1'b0;
        end else if (cnt_q >= limit - W'(1)) begin
            filtered <= 1'b1;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule

// ---- ldcr_host_model.sv ----
`timescale 1ns/1ps

// ============================================================
// Serial host: clock idles low, data on rise
// ============================================================
module ldcr_host_model (
    // Link
    input  wire logic clk,
    input  wire logic sdo,
    output logic      sclk,
    output logic      scs_n,
    output logic      sdi
);
    initial begin
        sclk  = 1'b0;
        scs_n = 1'b1;
        sdi   = 1'b0;
    end

    task automatic xfer(input logic [15:0] f, input int nb,
                        output logic [15:0] r);
        r = 16'h0000;
        @(posedge clk) #1 scs_n = 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            #1 sclk = 1'b1;
            sdi = f[15-i];
            repeat (3) @(posedge clk);
            #1 r = {r[14:0], sdo};
            sclk = 1'b0;
            repeat (3) @(posedge clk);
        end
        #1 scs_n = 1'b1;
        // A released data line must not look like the last bit.
        sdi = ~sdi;
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule

// ---- ldcr_pkg.sv ----
package ldcr_pkg;

    // ========================================================
    // Clock and serial frame layout
    // ========================================================
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned FRAME_BITS    = 16;
    localparam int unsigned CNT_W         = 5;
    localparam int unsigned RNW_BIT       = 14;
    localparam int unsigned ADDR_MSB      = 13;
    localparam int unsigned ADDR_LSB      = 8;
    localparam int unsigned DATA_MSB      = 7;
    localparam int unsigned ADDR_W        = 6;
    localparam int unsigned REG_W         = 8;
    localparam int unsigned PEEK_BITS     = 8;

    // ========================================================
    // Register map
    // ========================================================
    localparam logic [5:0] ADDR_EDGE_RATE_HI    = 6'h18;
    localparam logic [5:0] ADDR_OPENLOAD_DIS_LO = 6'h19;
    localparam logic [5:0] ADDR_OPENLOAD_CTRL   = 6'h1A;
    localparam logic [5:0] ADDR_DEGLITCH_LOWCUR = 6'h1B;
    localparam logic [5:0] ADDR_LOWCUR_LO       = 6'h24;
    localparam logic [7:0] REG_RESET            = 8'h00;
    localparam logic [7:0] READ_UNMAPPED        = 8'h00;

    // ========================================================
    // Field positions
    // ========================================================
    localparam int unsigned HI_BRIDGE_MSB       = 3;
    localparam int unsigned REPORT_SUPPRESS_BIT = 7;
    localparam int unsigned KEEP_RUNNING_BIT    = 6;
    localparam int unsigned PL_SLEW_MSB         = 5;
    localparam int unsigned PL_SLEW_LSB         = 4;
    localparam int unsigned DEG_MSB             = 7;
    localparam int unsigned DEG_LSB             = 5;
    localparam int unsigned NEG_EN_BIT          = 4;
    localparam logic [7:0]  PL_SLEW_READ_MASK   = 8'hCF;
    localparam logic [1:0]  PL_SLEW_FAST        = 2'h0;
    localparam logic [1:0]  PL_SLEW_SLOW        = 2'h1;

    // ========================================================
    // Overcurrent deglitch times
    // ========================================================
    typedef enum logic [2:0] {
        DEG_10US, DEG_5US, DEG_2P5US, DEG_1US,
        DEG_60US, DEG_40US, DEG_30US, DEG_20US
    } ldcr_deg_sel_t;

    localparam int unsigned DEG_CNT_W   = 13;
    localparam int unsigned DEG_10US_NS = 10000;
    localparam int unsigned DEG_5US_NS  = 5000;
    localparam int unsigned DEG_2P5US_NS = 2500;
    localparam int unsigned DEG_1US_NS  = 1000;
    localparam int unsigned DEG_60US_NS = 60000;
    localparam int unsigned DEG_40US_NS = 40000;
    localparam int unsigned DEG_30US_NS = 30000;
    localparam int unsigned DEG_20US_NS = 20000;

endpackage

// ---- ldcr_spi_if.sv ----
`timescale 1ns/1ps

interface ldcr_spi_if;
    logic       frame_valid;
    logic       frame_rnw;
    logic [5:0] frame_addr;
    logic [7:0] frame_wdata;
    logic [5:0] peek_addr;
    logic [7:0] peek_rdata;
    logic [7:0] status;

    modport slave (
        output frame_valid, frame_rnw, frame_addr, frame_wdata, peek_addr,
        input  peek_rdata, status
    );
    modport regs (
        input  frame_valid, frame_rnw, frame_addr, frame_wdata, peek_addr,
        output peek_rdata, status
    );
endinterface

// ---- ldcr_spi_slave.sv ----
`timescale 1ns/1ps

module ldcr_spi_slave (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // Serial pins
    input  wire logic   sclk,
    input  wire logic   scs_n,
    input  wire logic   sdi,
    output logic        sdo,
    output logic        sdo_oe,
    // Register side
    ldcr_spi_if.slave   bus
);
    logic [15:0] rx_q;
    logic [15:0] tx_q;
    logic [4:0]  cnt_q;
    logic        sclk_q;
    logic        scs_n_q;
    logic        rise;
    logic        fall;

    assign rise = ~sclk_q & sclk;
    assign fall = sclk_q & ~sclk;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_q  <= 1'b0;
            scs_n_q <= 1'b1;
        end else begin
            sclk_q  <= sclk;
            scs_n_q <= scs_n;
        end
    end

    // ========================================================
    // Receive shifter, sampled on the falling serial edge
    // ========================================================
    always_ff @(posedge clk) begin
        if (rst || scs_n) begin
            rx_q  <= 16'h0000;
            cnt_q <= 5'h00;
        end else if (fall) begin
            rx_q <= {rx_q[14:0], sdi};
            if (cnt_q != 5'h1F) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // ========================================================
    // Transmit shifter: status byte, then addressed register
    // ========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_q <= 16'h0000;
        end else if (scs_n_q && !scs_n) begin
            tx_q <= {bus.status, 8'h00};
        end else if (!scs_n && rise && cnt_q == 5'(ldcr_pkg::PEEK_BITS)) begin
            tx_q <= {bus.peek_rdata, 8'h00};
        end else if (!scs_n && rise && cnt_q != 5'h00) begin
            tx_q <= {tx_q[14:0], 1'b0};
        end
    end

    assign sdo    = tx_q[15];
    assign sdo_oe = ~scs_n;
    assign bus.peek_addr = rx_q[5:0];

    // A frame counts only if exactly sixteen bits arrived.
    always_ff @(posedge clk) begin // R17
        if (rst) begin
            bus.frame_valid <= 1'b0;
            bus.frame_rnw   <= 1'b0;
            bus.frame_addr  <= 6'h00;
            bus.frame_wdata <= 8'h00;
        end else begin
            bus.frame_valid <= !scs_n_q && scs_n
                && cnt_q == 5'(ldcr_pkg::FRAME_BITS);
            bus.frame_rnw   <= rx_q[ldcr_pkg::RNW_BIT];
            bus.frame_addr  <= rx_q[ldcr_pkg::ADDR_MSB:ldcr_pkg::ADDR_LSB];
            bus.frame_wdata <= rx_q[ldcr_pkg::DATA_MSB:0];
        end
    end
endmodule

// ---- ldcr_top.sv ----
`timescale 1ns/1ps

// Functional notes
// [R1] Edge-rate bits for bridges 9-12 pick slow edges at 0, fast at 1.
// [R2] First open-load register bit n-1 disables detection on bridge n.
// [R3] Second open-load register bits 3:0 disable bridges 12 down to 9.
// [R4] Report-suppress bit 7 at 0 lets open load pull the fault pin low.
// [R5] Keep-running bit 6 at 0 turns the bridges off after an open load.
// [R6] Parallel turn-off slew field 5:4 is fast at 00 and slow at 01.
// [R7] The host never writes 10 or 11 into the parallel slew field.
// [R8] The parallel slew field is write-only and always reads back zero.
// [R9] Deglitch field 7:5 selects 10, 5, 2.5, 1, 60, 40, 30 or 20 us.
// [R10] Third open-load register bit 4 enables negative-current mode.
// [R11] Third open-load register bits 3:0 enable low-current on 12-9.
// [R12] Fourth open-load register bit n-1 enables low-current on bridge n.
// [R13] The third open-load register sits at 0x1B and resets to zero.
// [R14] The fourth open-load register sits at 0x24 and resets to zero.
// [R15] The first two open-load registers sit at 0x19/0x1A, reset zero.
// [R16] The second edge-rate register sits at 0x18 and resets to zero.
// [R17] Reserved bits store writes; a frame commits all fields at its end.
module ldcr_top #(
    parameter int unsigned BRIDGES      = 12,
    parameter int unsigned DEG_60US_CYC =
        ldcr_pkg::DEG_60US_NS / ldcr_pkg::CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Serial link
    input  wire logic         sclk,
    input  wire logic         scs_n,
    input  wire logic         sdi,
    output logic              sdo,
    output logic              sdo_oe,
    // Detector inputs
    input  wire logic [11:0]  openload_raw,
    input  wire logic         overcurrent_raw,
    input  wire logic         clear_fault,
    // Configuration to the analogue side
    output logic [3:0]        bridge_edge_fast_hi,
    output logic [11:0]       open_load_detect_en,
    output logic [11:0]       lowcur_detect_en,
    output logic              negative_current_detect_en,
    output logic              parallel_turnoff_slow,
    // Fault and protection
    output logic              overcurrent_protect,
    output logic              bridges_off,
    output logic              fault_out_n
);

    // ========================================================
    // Elaboration checks
    // ========================================================
    if (BRIDGES != 12) begin : g_bad_bridges
        $error("Only twelve bridges are supported.");
    end
    if (DEG_60US_CYC < 1 || DEG_60US_CYC >= (1 << ldcr_pkg::DEG_CNT_W))
    begin : g_bad_deg
        $error("Long deglitch count does not fit the counter.");
    end

    localparam int unsigned CYC_NS    = ldcr_pkg::CLK_PERIOD_NS;
    localparam logic [12:0] CYC_10US  = 13'(ldcr_pkg::DEG_10US_NS / CYC_NS);
    localparam logic [12:0] CYC_5US   = 13'(ldcr_pkg::DEG_5US_NS / CYC_NS);
    localparam logic [12:0] CYC_2P5US = 13'(ldcr_pkg::DEG_2P5US_NS / CYC_NS);
    localparam logic [12:0] CYC_1US   = 13'(ldcr_pkg::DEG_1US_NS / CYC_NS);
    localparam logic [12:0] CYC_60US  = 13'(DEG_60US_CYC);
    localparam logic [12:0] CYC_40US  = 13'(ldcr_pkg::DEG_40US_NS / CYC_NS);
    localparam logic [12:0] CYC_30US  = 13'(ldcr_pkg::DEG_30US_NS / CYC_NS);
    localparam logic [12:0] CYC_20US  = 13'(ldcr_pkg::DEG_20US_NS / CYC_NS);

    // ========================================================
    // Register storage
    // ========================================================
    logic [7:0]  edge_rate_hi_q;
    logic [7:0]  openload_disable_lo_q;
    logic [7:0]  openload_ctrl_report_q;
    logic [7:0]  deglitch_lowcur_hi_q;
    logic [7:0]  lowcur_openload_lo_q;
    logic        wr_en;
    logic [11:0] ol_off;
    logic [11:0] ol_active;
    logic        ol_any;
    logic        bridges_off_q;
    logic        fault_n_q;
    logic [12:0] deg_limit;
    logic        report_suppress;
    logic        keep_running;

    ldcr_spi_if bus ();

    ldcr_spi_slave u_spi (
        .clk    (clk),
        .rst    (rst),
        .sclk   (sclk),
        .scs_n  (scs_n),
        .sdi    (sdi),
        .sdo    (sdo),
        .sdo_oe (sdo_oe),
        .bus    (bus)
    );

    assign wr_en = bus.frame_valid && !bus.frame_rnw;

    // ========================================================
    // Register writes, each committed whole at frame end
    // ========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            edge_rate_hi_q <= ldcr_pkg::REG_RESET; // R16
        end else if (wr_en
                     && bus.frame_addr == ldcr_pkg::ADDR_EDGE_RATE_HI) begin
            edge_rate_hi_q <= bus.frame_wdata; // R17
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            openload_disable_lo_q <= ldcr_pkg::REG_RESET; // R15
        end else if (wr_en
                     && bus.frame_addr == ldcr_pkg::ADDR_OPENLOAD_DIS_LO) begin
            openload_disable_lo_q <= bus.frame_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            openload_ctrl_report_q <= ldcr_pkg::REG_RESET; // R15
        end else if (wr_en
                     && bus.frame_addr == ldcr_pkg::ADDR_OPENLOAD_CTRL) begin
            openload_ctrl_report_q <= bus.frame_wdata; // R17
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            deglitch_lowcur_hi_q <= ldcr_pkg::REG_RESET; // R13
        end else if (wr_en
                     && bus.frame_addr == ldcr_pkg::ADDR_DEGLITCH_LOWCUR) begin
            deglitch_lowcur_hi_q <= bus.frame_wdata; // R13
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lowcur_openload_lo_q <= ldcr_pkg::REG_RESET; // R14
        end else if (wr_en
                     && bus.frame_addr == ldcr_pkg::ADDR_LOWCUR_LO) begin
            lowcur_openload_lo_q <= bus.frame_wdata; // R14
        end
    end

    // ========================================================
    // Read path, sampled by the serial slave mid-frame
    // ========================================================
    always_comb begin
        case (bus.peek_addr)
            ldcr_pkg::ADDR_EDGE_RATE_HI:
                bus.peek_rdata = edge_rate_hi_q; // R17
            ldcr_pkg::ADDR_OPENLOAD_DIS_LO:
                bus.peek_rdata = openload_disable_lo_q;
            ldcr_pkg::ADDR_OPENLOAD_CTRL:
                bus.peek_rdata = openload_ctrl_report_q
                               & ldcr_pkg::PL_SLEW_READ_MASK; // R8
            ldcr_pkg::ADDR_DEGLITCH_LOWCUR:
                bus.peek_rdata = deglitch_lowcur_hi_q;
            ldcr_pkg::ADDR_LOWCUR_LO:
                bus.peek_rdata = lowcur_openload_lo_q;
            default:
                bus.peek_rdata = ldcr_pkg::READ_UNMAPPED;
        endcase
    end

    // Reply status byte: bit 1 fault pin asserted (unsuppressed open load), bit 0 bridges held off.
    assign bus.status = {6'h00, ~fault_n_q, bridges_off_q};

    // ========================================================
    // Configuration outputs
    // ========================================================
    assign bridge_edge_fast_hi =
        edge_rate_hi_q[ldcr_pkg::HI_BRIDGE_MSB:0]; // R1
    assign ol_off = {openload_ctrl_report_q[ldcr_pkg::HI_BRIDGE_MSB:0],
                     openload_disable_lo_q}; // R2 R3
    assign lowcur_detect_en = {
        deglitch_lowcur_hi_q[ldcr_pkg::HI_BRIDGE_MSB:0],
        lowcur_openload_lo_q}; // R11 R12
    assign negative_current_detect_en =
        deglitch_lowcur_hi_q[ldcr_pkg::NEG_EN_BIT]; // R10

    // Codes 10 and 11 are invalid; they fall back to the fast edge.
    assign parallel_turnoff_slow = openload_ctrl_report_q[
        ldcr_pkg::PL_SLEW_MSB:ldcr_pkg::PL_SLEW_LSB]
        == ldcr_pkg::PL_SLEW_SLOW; // R6 R7

    assign report_suppress =
        openload_ctrl_report_q[ldcr_pkg::REPORT_SUPPRESS_BIT];
    assign keep_running = openload_ctrl_report_q[ldcr_pkg::KEEP_RUNNING_BIT];

    // ========================================================
    // Per-bridge open-load gating
    // ========================================================
    for (genvar i = 0; i < BRIDGES; i++) begin : g_bridge
        assign open_load_detect_en[i] = ~ol_off[i]; // R2 R3
        assign ol_active[i] = openload_raw[i] & ~ol_off[i];
    end

    assign ol_any = |ol_active;

    // The fault pin follows any enabled open load unless suppressed.
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_n_q <= 1'b1;
        end else begin
            fault_n_q <= ~(ol_any && !report_suppress); // R4
        end
    end

    assign fault_out_n = fault_n_q;

    // Bridges stay off after an open load until cleared; a new
    // detection in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (rst) begin
            bridges_off_q <= 1'b0;
        end else if (ol_any && !keep_running) begin
            bridges_off_q <= 1'b1; // R5
        end else if (clear_fault || keep_running) begin
            bridges_off_q <= 1'b0; // R5
        end
    end

    assign bridges_off = bridges_off_q;

    // ========================================================
    // Overcurrent deglitch
    // ========================================================
    always_comb begin
        case (ldcr_pkg::ldcr_deg_sel_t'(deglitch_lowcur_hi_q[
                ldcr_pkg::DEG_MSB:ldcr_pkg::DEG_LSB]))
            ldcr_pkg::DEG_10US:  deg_limit = CYC_10US; // R9
            ldcr_pkg::DEG_5US:   deg_limit = CYC_5US;
            ldcr_pkg::DEG_2P5US: deg_limit = CYC_2P5US;
            ldcr_pkg::DEG_1US:   deg_limit = CYC_1US;
            ldcr_pkg::DEG_60US:  deg_limit = CYC_60US;
            ldcr_pkg::DEG_40US:  deg_limit = CYC_40US;
            ldcr_pkg::DEG_30US:  deg_limit = CYC_30US;
            ldcr_pkg::DEG_20US:  deg_limit = CYC_20US;
            default:             deg_limit = CYC_10US;
        endcase
    end

    ldcr_deglitch #(
        .W (ldcr_pkg::DEG_CNT_W)
    ) u_deglitch (
        .clk      (clk),
        .rst      (rst),
        .raw      (overcurrent_raw),
        .limit    (deg_limit),
        .filtered (overcurrent_protect)
    );

endmodule

// ---- ldcr_top_asserts.sv ----
`timescale 1ns/1ps

// ============================================================
// Port checker
// ============================================================
module ldcr_top_asserts #(
    parameter int unsigned DEG_60US_CYC = 6000
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Serial link
    input  wire logic        scs_n,
    input  wire logic        sdo_oe,
    // Detectors
    input  wire logic [11:0] openload_raw,
    input  wire logic        overcurrent_raw,
    // Configuration and faults
    input  wire logic [3:0]  bridge_edge_fast_hi,
    input  wire logic [11:0] open_load_detect_en,
    input  wire logic [11:0] lowcur_detect_en,
    input  wire logic        parallel_turnoff_slow,
    input  wire logic        overcurrent_protect,
    input  wire logic        bridges_off,
    input  wire logic        fault_out_n
);
    localparam int MIN_DEG = (DEG_60US_CYC < 100) ? DEG_60US_CYC : 100;
    logic [15:0] oc_cnt_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Cycles that the overcurrent input has stood high.
    always_ff @(posedge clk) begin
        if (rst || !overcurrent_raw) begin
            oc_cnt_q <= 16'h0000;
        end else if (oc_cnt_q != 16'hFFFF) begin
            oc_cnt_q <= oc_cnt_q + 16'h0001;
        end
    end

    property p_edge_commit;
        $changed(bridge_edge_fast_hi) |-> $past(scs_n) && $past(scs_n, 2);
    endproperty
    a_edge_commit: assert property (p_edge_commit)
        else $error("edge rates moved mid-frame");
    property p_olen_commit;
        $changed(open_load_detect_en) |-> $past(scs_n) && $past(scs_n, 2);
    endproperty
    a_olen_commit: assert property (p_olen_commit)
        else $error("open-load enables moved mid-frame");
    property p_lowcur_commit;
        $changed(lowcur_detect_en) |-> $past(scs_n) && $past(scs_n, 2);
    endproperty
    a_lowcur_commit: assert property (p_lowcur_commit)
        else $error("low-current enables moved mid-frame");
    property p_fault_cause;
        !fault_out_n |-> $past(|(openload_raw & open_load_detect_en));
    endproperty
    a_fault_cause: assert property (p_fault_cause)
        else $error("fault low without open load");
    property p_off_cause;
        $rose(bridges_off) |-> $past(|(openload_raw & open_load_detect_en));
    endproperty
    a_off_cause: assert property (p_off_cause)
        else $error("bridges off without open load");
    property p_ocp_filter;
        $rose(overcurrent_protect) |-> oc_cnt_q >= MIN_DEG - 2;
    endproperty
    a_ocp_filter: assert property (p_ocp_filter)
        else $error("overcurrent before filter time");
    property p_ocp_drop;
        !overcurrent_raw |-> ##[1:2] !overcurrent_protect;
    endproperty
    a_ocp_drop: assert property (p_ocp_drop)
        else $error("overcurrent outlived its input");
    property p_rst_open;
        $fell(rst) |-> open_load_detect_en == 12'hFFF
            && lowcur_detect_en == 12'h000;
    endproperty
    a_rst_open: assert property (p_rst_open)
        else $error("enables wrong after reset");
    property p_rst_edge;
        $fell(rst) |-> bridge_edge_fast_hi == 4'h0 && !parallel_turnoff_slow;
    endproperty
    a_rst_edge: assert property (p_rst_edge)
        else $error("edge rates wrong after reset");
    property p_oe_select;
        sdo_oe == !scs_n;
    endproperty
    a_oe_select: assert property (p_oe_select)
        else $error("enable does not follow select");
endmodule

bind ldcr_top ldcr_top_asserts #(
    .DEG_60US_CYC (DEG_60US_CYC)
) i_ldcr_top_asserts (
    .clk (clk), .rst (rst), .scs_n (scs_n), .sdo_oe (sdo_oe),
    .openload_raw (openload_raw), .overcurrent_raw (overcurrent_raw),
    .bridge_edge_fast_hi (bridge_edge_fast_hi),
    .open_load_detect_en (open_load_detect_en),
    .lowcur_detect_en (lowcur_detect_en),
    .parallel_turnoff_slow (parallel_turnoff_slow),
    .overcurrent_protect (overcurrent_protect),
    .bridges_off (bridges_off), .fault_out_n (fault_out_n)
);

// ---- ldcr_top_bench.sv ----
`timescale 1ns/1ps

module ldcr_top_bench;
    localparam int unsigned DEG60 = 50;
    logic        clk, rst, sclk, scs_n, sdi, sdo, sdo_oe;
    logic [11:0] openload_raw, open_load_detect_en, lowcur_detect_en;
    logic        overcurrent_raw, clear_fault, negative_current_detect_en;
    logic [3:0]  bridge_edge_fast_hi;
    logic        parallel_turnoff_slow, overcurrent_protect;
    logic        bridges_off, fault_out_n;
    int          num_errors, check_count;

    ldcr_top #(.DEG_60US_CYC(DEG60)) i_ldcr_top (
        .clk(clk), .rst(rst), .sclk(sclk), .scs_n(scs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .openload_raw(openload_raw),
        .overcurrent_raw(overcurrent_raw), .clear_fault(clear_fault),
        .bridge_edge_fast_hi(bridge_edge_fast_hi),
        .open_load_detect_en(open_load_detect_en),
        .lowcur_detect_en(lowcur_detect_en),
        .negative_current_detect_en(negative_current_detect_en),
        .parallel_turnoff_slow(parallel_turnoff_slow),
        .overcurrent_protect(overcurrent_protect),
        .bridges_off(bridges_off), .fault_out_n(fault_out_n));
    ldcr_host_model i_ldcr_host_model (
        .clk(clk), .sdo(sdo), .sclk(sclk), .scs_n(scs_n), .sdi(sdi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ============================================================
    // Compare and access tasks
    // ============================================================
    task automatic chk_val(input logic [15:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask
    task automatic chk_lat(input int got, lo, hi);
        check_count++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("MISMATCH at %0t: delay %0d not in %0d..%0d", $time,
                     got, lo, hi);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] r;
        i_ldcr_host_model.xfer({2'b00, a, d}, 16, r);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic [15:0] r;
        i_ldcr_host_model.xfer({2'b01, a, 8'h00}, 16, r);
        chk_val(r[7:0], e, "read data");
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ============================================================
    // Scenarios
    // ============================================================
    task automatic t_reset();
        rd(6'h18, 8'h00);
        rd(6'h19, 8'h00);
        rd(6'h1A, 8'h00);
        rd(6'h1B, 8'h00);
        rd(6'h24, 8'h00);
        chk_val(open_load_detect_en, 12'hFFF, "open enables");
        chk_val(lowcur_detect_en, 12'h000, "low enables");
        chk_val(bridge_edge_fast_hi, 4'h0, "edge rates");
    endtask
    task automatic t_fields();
        wr(6'h18, 8'hA5);
        wr(6'h19, 8'h5A);
        wr(6'h1A, 8'h1B);
        wr(6'h1B, 8'h9C);
        wr(6'h24, 8'h96);
        chk_val(bridge_edge_fast_hi, 4'h5, "edge rates");
        chk_val(open_load_detect_en[7:0], 8'hA5, "open low");
        chk_val(open_load_detect_en[11:8], 4'h4, "open high");
        chk_val(lowcur_detect_en[11:8], 4'hC, "low high");
        chk_val(lowcur_detect_en[7:0], 8'h96, "low low");
        chk_val(negative_current_detect_en, 1'b1, "negative");
        chk_val(parallel_turnoff_slow, 1'b1, "slow");
        rd(6'h18, 8'hA5);
        rd(6'h19, 8'h5A);
        rd(6'h1A, 8'h0B);
        rd(6'h1B, 8'h9C);
        wr(6'h1A, 8'h0B);
        wr(6'h1B, 8'h8C);
        chk_val(parallel_turnoff_slow, 1'b0, "fast");
        chk_val(negative_current_detect_en, 1'b0, "negative");
    endtask
    task automatic t_refuse();
        logic [15:0] r;
        wr(6'h25, 8'hFF);
        rd(6'h25, 8'h00);
        i_ldcr_host_model.xfer({2'b00, 6'h24, 8'h00}, 15, r);
        rd(6'h24, 8'h96);
    endtask
    task automatic t_openload();
        openload_raw = 12'h002;
        wait_clk(3);
        chk_val(fault_out_n, 1'b1, "fault");
        openload_raw = 12'h001;
        wait_clk(3);
        chk_val(fault_out_n, 1'b0, "fault");
        chk_val(bridges_off, 1'b1, "off");
        openload_raw = 12'h000;
        wait_clk(3);
        chk_val(fault_out_n, 1'b1, "fault");
        clear_fault = 1'b1;
        wait_clk(1);
        clear_fault = 1'b0;
        wait_clk(2);
        chk_val(bridges_off, 1'b0, "off");
        wr(6'h1A, 8'hCB);
        openload_raw = 12'h001;
        wait_clk(3);
        chk_val(fault_out_n, 1'b1, "fault");
        chk_val(bridges_off, 1'b0, "off");
        openload_raw = 12'h000;
    endtask
    task automatic t_deglitch();
        int lim [8];
        int n;
        lim = '{1000, 500, 250, 100, DEG60, 4000, 3000, 2000};
        for (int c = 0; c < 8; c++) begin
            wr(6'h1B, {c[2:0], 5'h0C});
            overcurrent_raw = 1'b1;
            n = 0;
            while (overcurrent_protect !== 1'b1 && n < 5000) begin
                wait_clk(1);
                n++;
            end
            chk_lat(n, lim[c] - 1, lim[c] + 2);
            overcurrent_raw = 1'b0;
            wait_clk(2);
            chk_val(overcurrent_protect, 1'b0, "overcurrent");
        end
    endtask

    // ============================================================
    // Run control
    // ============================================================
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        rst             = 1'b1;
        openload_raw    = 12'h000;
        overcurrent_raw = 1'b0;
        clear_fault     = 1'b0;
        num_errors      = 0;
        check_count     = 0;
        wait_clk(4);
        rst = 1'b0;
        wait_clk(2);
        t_reset();
        t_fields();
        t_refuse();
        t_openload();
        t_deglitch();
        close_out();
    end

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
